// File: rtl/fsg_pkg.sv
// Package of constants and carrier types for the flash section guard.
package fsg_pkg;

    // Flash word map, 128K variant.
    localparam logic [16:0] FLASH_TABLE_START = 17'h0f000;
    localparam logic [16:0] FLASH_BOOT_START  = 17'h10000;
    localparam logic [16:0] FLASH_BOOT_END    = 17'h10fff;
    localparam int          FLASH_WORD_BITS   = 16;

    // Data-space byte map.
    localparam logic [15:0] DATA_IO_END       = 16'h0fff;
    localparam logic [15:0] DATA_EE_START     = 16'h1000;
    localparam logic [15:0] DATA_SRAM_START   = 16'h2000;
    localparam logic [7:0]  DATA_GAP_READ     = 8'hff;

    // Lock field layout: bit 0 blocks writes, bit 1 blocks reads; zero means programmed.
    localparam int          LOCK_WR_BIT       = 0;
    localparam int          LOCK_RD_BIT       = 1;
    localparam logic [5:0]  LOCK_RESET        = 6'h3f;
    localparam int          LOCK_APP_POS      = 0;
    localparam int          LOCK_TABLE_POS    = 2;
    localparam int          LOCK_BOOT_POS     = 4;

    // Fuse layout.
    localparam logic [7:0]  FUSE_RESET        = 8'hff;
    localparam int          FUSE_BOD_BIT      = 0;
    localparam int          FUSE_WDT_BIT      = 1;
    localparam int          FUSE_STARTUP_POS  = 2;

    // Signature row layout.
    localparam logic [7:0]  SIG_ID0_IDX       = 8'h00;
    localparam logic [7:0]  SIG_ID1_IDX       = 8'h01;
    localparam logic [7:0]  SIG_ID2_IDX       = 8'h02;
    localparam logic [7:0]  SIG_CAL_IDX       = 8'h04;
    localparam logic [7:0]  SIG_SERIAL_IDX    = 8'h08;
    localparam int          SIG_CAL_LOADS     = 2;

    typedef enum logic [1:0] {
        SEC_APP   = 2'b00,
        SEC_TABLE = 2'b01,
        SEC_BOOT  = 2'b10
    } fsg_section_t;

    typedef enum logic [1:0] {
        DSEL_IO   = 2'b00,
        DSEL_EE   = 2'b01,
        DSEL_SRAM = 2'b10,
        DSEL_NONE = 2'b11
    } fsg_dsel_t;

    typedef enum logic [1:0] {
        ST_CAL    = 2'b00,
        ST_RUN    = 2'b01,
        ST_ERASE  = 2'b10,
        ST_UNLOCK = 2'b11
    } fsg_state_t;

    // One flash request from either master.
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [16:0] addr;
    } fsg_freq_t;

endpackage : fsg_pkg

// File: rtl/fsg_guard.sv
// Flash section guard, lock and fuse keeper, and data-space decoder.
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps

module fsg_guard
    import fsg_pkg::*;
#(
    parameter logic [7:0] DEV_ID0   = 8'h5a,  // Arbitrary identity value.
    parameter logic [7:0] DEV_ID1   = 8'h5b,  // Arbitrary identity value.
    parameter logic [7:0] DEV_ID2   = 8'h5c,  // Arbitrary identity value.
    parameter logic [7:0] SERIAL    = 8'h00,
    parameter logic [7:0] CAL0      = 8'h80,
    parameter logic [7:0] CAL1      = 8'h40,
    parameter int         EE_BYTES  = 2048,
    parameter int         PAGE_WRDS = 256
) (
    // Clock and reset.
    input  wire logic        clock,
    input  wire logic        rst,
    // CPU flash port.
    input  wire fsg_freq_t   cpuReq,
    input  wire logic        cpuStore,
    input  wire logic [16:0] cpuPc,
    output logic             cpuGrant,
    output logic             cpuDenied,
    // Debug port flash and configuration access.
    input  wire fsg_freq_t   dbgReq,
    output logic             dbgGrant,
    output logic             dbgDenied,
    input  wire logic        dbgFuseWr,
    input  wire logic [7:0]  dbgFuseData,
    input  wire logic        dbgLockWr,
    input  wire logic [5:0]  dbgLockData,
    input  wire logic        dbgChipErase,
    // Flash array side.
    output logic             flashErase,
    input  wire logic        flashEraseDone,
    // Software configuration access.
    input  wire logic        swLockWr,
    input  wire logic [5:0]  swLockData,
    input  wire logic        swFuseWr,
    input  wire logic [7:0]  swFuseData,
    output logic [5:0]       lockBits,
    output logic [7:0]       fuseBits,
    // Signature rows.
    input  wire logic        sigRd,
    input  wire logic        sigWr,
    input  wire logic        sigUser,
    input  wire logic [7:0]  sigAddr,
    input  wire logic [7:0]  sigWdata,
    input  wire logic        userRowErase,
    output logic [7:0]       sigRdata,
    output logic             sigWrDenied,
    // Calibration loading.
    output logic [7:0]       oscCal,
    output logic [7:0]       anaCal,
    output logic             calDone,
    // Fuse-driven configuration.
    output logic             bodEnable,
    output logic             wdtEnable,
    output logic [1:0]       startupSel,
    // Data-space decode.
    input  wire logic [15:0] dataAddr,
    input  wire logic        dataRd,
    input  wire logic        dataWr,
    input  wire logic        eeMapEn,
    output fsg_dsel_t        dataSel,
    output logic             dataWrEn,
    output logic             dataGapRead,
    output logic [7:0]       dataGapData
);

    typedef struct packed {
        fsg_state_t  state;
        logic        calIdx;
        logic [5:0]  lock;
        logic [7:0]  fuse;
        logic        cpuGrant;
        logic        cpuDenied;
        logic        dbgGrant;
        logic        dbgDenied;
        logic        erase;
        logic [7:0]  sigRdata;
        logic        sigWrDenied;
        logic [7:0]  oscCal;
        logic [7:0]  anaCal;
        logic        gapRead;
    } fsg_regs_t;

    fsg_regs_t r;
    fsg_regs_t next_r;

    // User signature row: one page of flash words, kept as bytes.
    localparam int USER_BYTES = PAGE_WRDS * (FLASH_WORD_BITS / 8);
    logic [7:0] userRow [USER_BYTES];
    logic [7:0] userIdx;

    assign userIdx = sigAddr;

    // Section of a word address; table sized to match boot.
    function automatic fsg_section_t sectionOf(input logic [16:0] a);
        if (a >= FLASH_BOOT_START) begin
            return SEC_BOOT;
        end else if (a >= FLASH_TABLE_START) begin
            return SEC_TABLE;
        end
        return SEC_APP;
    endfunction : sectionOf

    function automatic logic [1:0] lockOf(input logic [5:0] l, input fsg_section_t s);
        unique case (s)
            SEC_APP:   return l[LOCK_APP_POS +: 2];
            SEC_TABLE: return l[LOCK_TABLE_POS +: 2];
            default:   return l[LOCK_BOOT_POS +: 2];
        endcase
    endfunction : lockOf

    // Lock field zero blocks the access; a field reads one when unprogrammed.
    function automatic logic allowed(input logic [5:0] l, input fsg_freq_t q);
        logic [1:0] f;
        f = lockOf(l, sectionOf(q.addr));
        if (q.addr > FLASH_BOOT_END) begin
            return 1'b0;
        end
        return (q.rd && f[LOCK_RD_BIT]) || (q.wr && f[LOCK_WR_BIT]);
    endfunction : allowed

    function automatic logic [7:0] sigByte(input logic [7:0] a);
        unique case (a)
            SIG_ID0_IDX:        return DEV_ID0;
            SIG_ID1_IDX:        return DEV_ID1;
            SIG_ID2_IDX:        return DEV_ID2;
            SIG_CAL_IDX:        return CAL0;
            SIG_CAL_IDX + 8'h01: return CAL1;
            SIG_SERIAL_IDX:     return SERIAL;
            default:            return 8'hff;
        endcase
    endfunction : sigByte

    logic       cpuWrite;
    logic       cpuOk;

    always_comb begin
        next_r = r;
        next_r.cpuGrant    = 1'b0;
        next_r.cpuDenied   = 1'b0;
        next_r.dbgGrant    = 1'b0;
        next_r.dbgDenied   = 1'b0;
        next_r.sigWrDenied = 1'b0;
        next_r.gapRead     = 1'b0;
        // A store only counts when fetched from the boot section; the target may be in any section.
        cpuWrite = cpuReq.wr && cpuStore && (sectionOf(cpuPc) == SEC_BOOT);
        cpuOk = 1'b0;
        unique case (r.state)
            ST_CAL: begin
                // Reset-time copy of the factory calibration bytes.
                if (r.calIdx == 1'b0) begin
                    next_r.oscCal = sigByte(SIG_CAL_IDX);
                    next_r.calIdx = 1'b1;
                end else begin
                    next_r.anaCal = sigByte(SIG_CAL_IDX + 8'h01);
                    next_r.state  = ST_RUN;
                end
            end
            ST_RUN: begin
                if (cpuReq.rd || cpuReq.wr) begin
                    cpuOk = allowed(r.lock, fsg_freq_t'{rd: cpuReq.rd, wr: cpuWrite, addr: cpuReq.addr});
                    next_r.cpuGrant  = cpuOk;
                    next_r.cpuDenied = !cpuOk;
                end
                if (dbgReq.rd || dbgReq.wr) begin
                    next_r.dbgGrant  = allowed(r.lock, dbgReq);
                    next_r.dbgDenied = !allowed(r.lock, dbgReq);
                end
                // Bits may only move from one to zero, whoever writes.
                if (dbgLockWr && ((dbgLockData & ~r.lock) == 6'h00)) begin
                    next_r.lock = dbgLockData;
                end else if (swLockWr && ((swLockData & ~r.lock) == 6'h00)) begin
                    next_r.lock = swLockData;
                end
                if (dbgFuseWr) begin
                    next_r.fuse = dbgFuseData;
                end
                if (sigRd) begin
                    next_r.sigRdata = sigUser ? userRow[userIdx] : sigByte(sigAddr);
                end
                next_r.sigWrDenied = sigWr && !sigUser;
                if (dbgChipErase) begin
                    next_r.erase = 1'b1;
                    next_r.state = ST_ERASE;
                end
            end
            ST_ERASE: begin
                // Locks stay in force until the array reports it is blank.
                if (flashEraseDone) begin
                    next_r.erase = 1'b0;
                    next_r.state = ST_UNLOCK;
                end
            end
            ST_UNLOCK: begin
                next_r.lock  = LOCK_RESET;
                next_r.state = ST_RUN;
            end
        endcase
        next_r.gapRead = dataRd && (dataSel == DSEL_NONE);
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            r <= '{state: ST_CAL, lock: LOCK_RESET, fuse: FUSE_RESET, default: '0};
        end else begin
            r <= next_r;
        end
    end

    // The user row is erased only by its own command; chip erase never touches it.
    always_ff @(posedge clock) begin
        if (userRowErase) begin
            for (int i = 0; i < USER_BYTES; i++) begin
                userRow[i] <= 8'hff;
            end
        end else if (sigWr && sigUser && r.state == ST_RUN) begin
            userRow[userIdx] <= sigWdata;
        end
    end

    // Data-space decode depends on EE_BYTES, which sets where the mapped EEPROM range ends.
    always_comb begin
        if (dataAddr <= DATA_IO_END) begin
            dataSel = DSEL_IO;
        end else if (dataAddr >= DATA_SRAM_START) begin
            dataSel = DSEL_SRAM;
        end else if (eeMapEn && dataAddr < DATA_EE_START + 16'(EE_BYTES)) begin
            dataSel = DSEL_EE;
        end else begin
            dataSel = DSEL_NONE;
        end
    end

    assign dataWrEn    = dataWr && (dataSel != DSEL_NONE);
    assign dataGapRead = r.gapRead;
    assign dataGapData = DATA_GAP_READ;

    assign cpuGrant    = r.cpuGrant;
    assign cpuDenied   = r.cpuDenied;
    assign dbgGrant    = r.dbgGrant;
    assign dbgDenied   = r.dbgDenied;
    assign flashErase  = r.erase;
    assign lockBits    = r.lock;
    assign fuseBits    = r.fuse;
    assign sigRdata    = r.sigRdata;
    assign sigWrDenied = r.sigWrDenied;
    assign oscCal      = r.oscCal;
    assign anaCal      = r.anaCal;
    assign calDone     = (r.state != ST_CAL);
    // Programmed fuse bits are zero, so the enables are the inverse.
    assign bodEnable   = !r.fuse[FUSE_BOD_BIT];
    assign wdtEnable   = !r.fuse[FUSE_WDT_BIT];
    assign startupSel  = r.fuse[FUSE_STARTUP_POS +: 2];

    // Software fuse writes are accepted on the port but have no effect.
    logic unusedSwFuse;
    assign unusedSwFuse = swFuseWr ^ (^swFuseData);

endmodule : fsg_guard

// File: tb/fsg_guard_sva.sv
// Port checker for the flash section guard.
`timescale 1ns/1ps
module fsg_guard_sva
    import fsg_pkg::*;
(
    // Clock and reset.
    input wire logic        clock,
    input wire logic        rst,
    // Watched ports.
    input wire fsg_freq_t   cpuReq,
    input wire logic        cpuStore,
    input wire logic [16:0] cpuPc,
    input wire logic        cpuGrant,
    input wire logic        cpuDenied,
    input wire logic        calDone,
    input wire logic        flashErase,
    input wire logic        flashEraseDone,
    input wire logic [5:0]  lockBits,
    input wire logic [7:0]  fuseBits,
    input wire logic        swFuseWr,
    input wire logic        dbgFuseWr,
    input wire logic [7:0]  dbgFuseData,
    input wire logic        bodEnable,
    input wire logic        wdtEnable,
    input wire logic        sigWr,
    input wire logic        sigUser,
    input wire logic        sigWrDenied,
    input wire logic [15:0] dataAddr,
    input wire fsg_dsel_t   dataSel
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    property p_boot_only;
        cpuReq.wr && cpuStore && cpuPc < FLASH_BOOT_START && calDone && !flashErase |=> cpuDenied && !cpuGrant;
    endproperty
    a_boot_only: assert property (p_boot_only)
        else $error("store outside boot section not refused");

    property p_answer;
        (cpuReq.rd || cpuReq.wr) && calDone && !flashErase |=> cpuGrant ^ cpuDenied;
    endproperty
    a_answer: assert property (p_answer)
        else $error("flash request got no single answer");

    property p_above_end;
        cpuReq.rd && cpuReq.addr > FLASH_BOOT_END && calDone && !flashErase |=> cpuDenied;
    endproperty
    a_above_end: assert property (p_above_end)
        else $error("address past boot end not refused");

    property p_lock_mono;
        !flashErase && !$past(flashErase) && !$past(flashErase, 2) |=> (lockBits & ~$past(lockBits)) == 6'h00;
    endproperty
    a_lock_mono: assert property (p_lock_mono)
        else $error("lock bit went back to unprogrammed");

    property p_erase_keep;
        flashErase && !flashEraseDone |=> $stable(lockBits);
    endproperty
    a_erase_keep: assert property (p_erase_keep)
        else $error("locks changed before erase finished");

    property p_fuse_sw;
        swFuseWr && !dbgFuseWr |=> $stable(fuseBits);
    endproperty
    a_fuse_sw: assert property (p_fuse_sw)
        else $error("software changed fuses");

    property p_fuse_dbg;
        dbgFuseWr |=> fuseBits == $past(dbgFuseData);
    endproperty
    a_fuse_dbg: assert property (p_fuse_dbg)
        else $error("debug fuse write not taken");

    property p_cfg;
        bodEnable == !fuseBits[FUSE_BOD_BIT] && wdtEnable == !fuseBits[FUSE_WDT_BIT];
    endproperty
    a_cfg: assert property (p_cfg)
        else $error("fuse driven enables disagree");

    property p_sig_ro;
        sigWr && !sigUser |=> sigWrDenied;
    endproperty
    a_sig_ro: assert property (p_sig_ro)
        else $error("production row write not refused");

    property p_data_sram;
        dataAddr >= DATA_SRAM_START |-> dataSel == DSEL_SRAM;
    endproperty
    a_data_sram: assert property (p_data_sram)
        else $error("sram range not selected");

    c_erase: cover property ($fell(flashErase));
    c_denied: cover property (cpuDenied);
    c_gap: cover property (dataSel == DSEL_NONE);
endmodule : fsg_guard_sva

bind fsg_guard fsg_guard_sva i_fsg_guard_sva (.clock, .rst, .cpuReq, .cpuStore, .cpuPc, .cpuGrant, .cpuDenied,
    .calDone, .flashErase, .flashEraseDone, .lockBits, .fuseBits, .swFuseWr, .dbgFuseWr, .dbgFuseData,
    .bodEnable, .wdtEnable, .sigWr, .sigUser, .sigWrDenied, .dataAddr, .dataSel);

// File: tb/fsg_flash_model.sv
// Flash array model that finishes a chip erase after a fixed delay.
`timescale 1ns/1ps
module fsg_flash_model #(
    parameter int ERASE_CYCLES = 12
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // Erase handshake.
    input wire logic flashErase,
    output logic     flashEraseDone
);
    int count;

    // The done pulse is one cycle; the count restarts once erase drops.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count <= 0;
            flashEraseDone <= 1'b0;
        end else begin
            flashEraseDone <= flashErase && count == ERASE_CYCLES - 1;
            count <= (flashErase && count < ERASE_CYCLES) ? count + 1 : 0;
        end
    end
endmodule : fsg_flash_model

// File: tb/fsg_guard_test.sv
// Directed testbench for the flash section guard.
`timescale 1ns/1ps
module fsg_guard_test
    import fsg_pkg::*;
;
    logic clock, rst, cpuStore, cpuGrant, cpuDenied, dbgGrant, dbgDenied, dbgFuseWr, dbgLockWr, dbgChipErase;
    logic flashErase, flashEraseDone, swLockWr, swFuseWr, sigRd, sigWr, sigUser, userRowErase, sigWrDenied;
    logic calDone, bodEnable, wdtEnable, dataRd, dataWr, eeMapEn, dataWrEn, dataGapRead;
    logic [16:0] cpuPc;
    logic [7:0]  dbgFuseData, swFuseData, fuseBits, sigAddr, sigWdata, sigRdata, oscCal, anaCal, dataGapData;
    logic [5:0]  dbgLockData, swLockData, lockBits;
    logic [1:0]  startupSel;
    logic [15:0] dataAddr;
    fsg_freq_t   cpuReq, dbgReq;
    fsg_dsel_t   dataSel;
    int          fails, compares;
    // Identity bytes are arbitrary.
    logic [7:0]  ids[3] = '{8'h31, 8'h32, 8'h33};
    logic [15:0] addrs[7] = '{16'h0000, 16'h0fff, 16'h1000, 16'h17ff, 16'h1800, 16'h1fff, 16'h2000};
    fsg_dsel_t   sels[7] = '{DSEL_IO, DSEL_IO, DSEL_EE, DSEL_EE, DSEL_NONE, DSEL_NONE, DSEL_SRAM};

    fsg_guard #(.DEV_ID0(8'h31), .DEV_ID1(8'h32), .DEV_ID2(8'h33), .CAL0(8'h81), .CAL1(8'h42)) i_fsg_guard (.*);
    fsg_flash_model i_fsg_flash_model (.clock, .rst, .flashErase, .flashEraseDone);

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic tally_and_finish();
        $display("Summary: %0d compares, %0d fails", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        compares++;
        if (seen !== expected) begin
            fails++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, expected);
        end
    endtask : check

    task automatic waitLevel(ref logic sig, input logic level);
        int n;
        for (n = 0; n < 50 && sig !== level; n++) begin
            @(posedge clock);
            #1;
        end
        if (n == 50) begin
            fails++;
            tally_and_finish();
        end
    endtask : waitLevel

    // A write is a store with rd low; the grant pair is looked at in its one valid cycle.
    task automatic flashReq(input logic dbg, input logic rd, input logic [16:0] addr, input logic [16:0] pc,
                            input logic grant);
        @(posedge clock);
        if (dbg) dbgReq <= '{rd, !rd, addr};
        else cpuReq <= '{rd, !rd, addr};
        cpuStore <= !dbg && !rd;
        cpuPc <= pc;
        @(posedge clock);
        cpuReq <= '0;
        dbgReq <= '0;
        cpuStore <= 1'b0;
        #1;
        check(dbg ? dbgGrant : cpuGrant, grant);
        check(dbg ? dbgDenied : cpuDenied, !grant);
    endtask : flashReq

    // Kind 0 software lock, 1 debug lock, 2 software fuse, 3 debug fuse.
    task automatic cfgWr(input int kind, input logic [7:0] data);
        @(posedge clock);
        swLockData <= data[5:0];
        dbgLockData <= data[5:0];
        swFuseData <= data;
        dbgFuseData <= data;
        {swLockWr, dbgLockWr, swFuseWr, dbgFuseWr} <= 4'b1000 >> kind;
        @(posedge clock);
        {swLockWr, dbgLockWr, swFuseWr, dbgFuseWr} <= 4'h0;
        #1;
    endtask : cfgWr

    task automatic sigAcc(input logic wr, input logic user, input logic [7:0] addr, input logic [7:0] wdata,
                          input logic [7:0] expected);
        @(posedge clock);
        sigUser <= user;
        sigAddr <= addr;
        sigWdata <= wdata;
        sigWr <= wr;
        @(posedge clock);
        sigWr <= 1'b0;
        sigRd <= 1'b1;
        #1;
        if (wr) check(sigWrDenied, !user);
        @(posedge clock);
        sigRd <= 1'b0;
        #1;
        check(sigRdata, expected);
    endtask : sigAcc

    initial begin
        {cpuReq, dbgReq, cpuStore, cpuPc, dbgFuseWr, dbgFuseData, dbgLockWr, dbgLockData, dbgChipErase, swLockWr,
         swLockData, swFuseWr, swFuseData, sigRd, sigWr, sigUser, sigAddr, sigWdata, userRowErase, dataAddr, dataRd,
         dataWr, eeMapEn} = '0;
        rst = 1'b1;
        repeat (6) @(posedge clock);
        #1;
        check({lockBits, fuseBits}, {LOCK_RESET, FUSE_RESET});
        rst <= 1'b0;
        waitLevel(calDone, 1'b1);
        check({oscCal, anaCal}, 16'h8142);
        $display("test reset done");
        flashReq(0, 1, 17'h0f000, 17'h0, 1);
        flashReq(0, 1, 17'h10fff, 17'h0, 1);
        flashReq(0, 1, 17'h11000, 17'h0, 0);
        flashReq(0, 0, 17'h00010, 17'h00100, 0);
        flashReq(0, 0, 17'h10000, 17'h10000, 1);
        flashReq(1, 0, 17'h00000, 17'h0, 1);
        flashReq(1, 1, 17'h10800, 17'h0, 1);
        $display("test map done");
        cfgWr(0, 8'h2f);
        check(lockBits, 6'h2f);
        flashReq(0, 0, 17'h10000, 17'h10000, 0);
        flashReq(0, 1, 17'h10000, 17'h0, 1);
        flashReq(0, 0, 17'h00020, 17'h10800, 1);
        cfgWr(0, 8'h3f);
        check(lockBits, 6'h2f);
        cfgWr(1, 8'h27);
        check(lockBits, 6'h27);
        flashReq(0, 1, 17'h0f000, 17'h0, 0);
        flashReq(0, 1, 17'h0efff, 17'h0, 1);
        $display("test locks done");
        cfgWr(2, 8'h00);
        check(fuseBits, FUSE_RESET);
        cfgWr(3, 8'hf6);
        check(fuseBits, 8'hf6);
        check({bodEnable, wdtEnable, startupSel}, 4'b1001);
        $display("test fuses done");
        for (int i = 0; i < 3; i++) sigAcc(0, 0, SIG_ID0_IDX + 8'(i), 8'h00, ids[i]);
        sigAcc(1, 0, SIG_ID0_IDX, 8'h00, ids[0]);
        sigAcc(1, 1, 8'h03, 8'ha5, 8'ha5);
        $display("test rows done");
        @(posedge clock);
        dbgChipErase <= 1'b1;
        @(posedge clock);
        dbgChipErase <= 1'b0;
        waitLevel(flashErase, 1'b1);
        check(lockBits, 6'h27);
        waitLevel(flashErase, 1'b0);
        repeat (2) @(posedge clock);
        #1;
        check(lockBits, LOCK_RESET);
        sigAcc(0, 1, 8'h03, 8'h00, 8'ha5);
        @(posedge clock);
        userRowErase <= 1'b1;
        @(posedge clock);
        userRowErase <= 1'b0;
        sigAcc(0, 1, 8'h03, 8'h00, 8'hff);
        $display("test erase done");
        eeMapEn <= 1'b1;
        foreach (addrs[i]) begin
            @(posedge clock);
            dataAddr <= addrs[i];
            dataRd <= 1'b1;
            dataWr <= 1'b1;
            #1;
            check(dataSel, sels[i]);
            check(dataWrEn, sels[i] != DSEL_NONE);
            @(posedge clock);
            #1;
            check(dataGapRead, sels[i] == DSEL_NONE);
        end
        check(dataGapData, DATA_GAP_READ);
        dataRd <= 1'b0;
        dataWr <= 1'b0;
        $display("test data map done");
        tally_and_finish();
    end
endmodule : fsg_guard_test
